// *** rtl/pft_control.sv ***
// Design decisions made here: strobed register access and the register offsets.
`timescale 1ns/10ps
// What this block does
// - Fault handling on only with extended enable and nonzero fault mode.
// - Four fault inputs, each with input and filter enable; shared filter value.
// - Inputs synchronised, then a 5-bit counter counts while input differs from filtered level, clears when equal.
// - New level accepted after counter reaches filter value; glitches dropped.
// - Filter off: two-edge delay, flag set on third edge.
// - Filter on: delay three plus value, flag at four plus value.
// - Enabled rising edge sets input flag; summary flag is OR of flags.
// - Fault edge with pair enable forces both pair outputs to polarity.
// - Interrupt while summary flag and enable; cleared by read-1-write-0.
// - Auto mode: outputs return when fault input low and new cycle.
// - Manual mode: outputs return when flag cleared and new cycle.
// - Polarity 0 means active high, 1 means active low.
// - Writing the init strobe drives stored initial values to outputs.
// - Features other than the capture test act only in combine mode.
// - With extended enable, selected channel matches emit triggers.
// - Reload trigger whenever counter loads its initial value.
// - Capture test: counter frozen, byte writes load counter directly.
// - Capture test: both bytes written update channel values and set flags.
// - Capture test: reads return written value and next counter value.
module pft_control
    import pft_pkg::*;
(
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst,
    // Register port
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    // Fault pins
    input wire logic [NUM_FAULT-1:0] i_fault_pin,
    // Counter and channel stages
    input wire logic [15:0] i_counter_value,
    input wire logic [15:0] i_counter_initial_value,
    input wire logic [15:0] i_counter_modulo,
    input wire logic [NUM_CH*16-1:0] i_channel_value,
    input wire logic [NUM_CH-1:0] i_channel_pwm,
    input wire logic i_counter_sync,
    input wire logic i_clock_start,
    // Outputs
    output logic [NUM_CH-1:0] o_channel_out,
    output logic [NUM_CH-1:0] o_match_trigger,
    output logic o_reload_trigger,
    output logic o_fault_irq,
    output logic o_counter_freeze,
    output logic o_counter_load,
    output logic [15:0] o_counter_load_value,
    output logic o_capture_load,
    output logic [15:0] o_capture_value,
    output logic [NUM_CH-1:0] o_channel_event_flag_set
);
    pft_bus_t bus;
    assign bus = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

    logic [7:0] mode_reg;
    logic [7:0] fault_ctrl;
    logic [3:0] fault_filter_value;
    logic [NUM_CH-1:0] channel_polarity;
    logic [NUM_CH-1:0] channel_initial_output;
    logic [6:0] trig_ctrl;
    logic [NUM_PAIR-1:0] pair_fault_enable;
    logic [NUM_FAULT-1:0] per_input_fault_flag;
    logic [NUM_FAULT-1:0] fault_input_status;
    logic [NUM_FAULT-1:0] sync1;
    logic [NUM_FAULT-1:0] sync2;
    logic [NUM_FAULT-1:0] cond_q;
    logic fault_or_q;
    logic fault_active;
    logic flag_seen_one;
    logic init_hold;
    logic [NUM_CH-1:0] init_val;
    logic hi_written;
    logic lo_written;
    logic [7:0] cap_hi;
    logic [7:0] cap_lo;
    logic [15:0] prev_counter;
    logic [7:0] rdata;

    wire extended_feature_enable = mode_reg[MODE_EXT_BIT];
    wire [1:0] fault_mode_select = mode_reg[MODE_FM_LSB +: 2];
    wire fault_interrupt_enable = mode_reg[MODE_FIE_BIT];
    wire capture_test_enable = mode_reg[MODE_CAPT_BIT];
    wire combine = mode_reg[MODE_COMB_BIT];
    wire [NUM_FAULT-1:0] fault_input_enable = fault_ctrl[3:0];
    wire [NUM_FAULT-1:0] fault_filter_enable = fault_ctrl[7:4];
    wire [NUM_CH-1:0] match_trigger_select = trig_ctrl[5:0];
    wire reload_trigger_enable = trig_ctrl[TRIG_RELOAD_BIT];

    wire fault_ctl_en = extended_feature_enable && (fault_mode_select != FM_OFF)
                        && combine;
    wire summary_fault_flag = |per_input_fault_flag;

    wire wr_mode = bus.wr && (bus.addr == ADDR_MODE);
    wire wr_fctl = bus.wr && (bus.addr == ADDR_FLTCTRL);
    wire wr_fstat = bus.wr && (bus.addr == ADDR_FLTSTAT);
    wire wr_cnth = bus.wr && (bus.addr == ADDR_CNTH);
    wire wr_cntl = bus.wr && (bus.addr == ADDR_CNTL);
    wire init_strobe = wr_mode && bus.wdata[MODE_INIT_BIT];
    // Flag clear needs a prior read of the flag as one
    wire flag_clear = wr_fstat && flag_seen_one && !bus.wdata[7];

    // Filter per input
    logic [NUM_FAULT-1:0] cond_in;
    genvar g;
    generate
        for (g = 0; g < NUM_FAULT; g++) begin : g_flt
            logic [FILT_W-1:0] cnt;
            logic state;
            wire bypass = (fault_filter_value == 4'h0) || !fault_filter_enable[g]
                          || !fault_input_enable[g];
            always_ff @(posedge i_mclk or posedge i_rst) begin
                if (i_rst) begin
                    cnt <= FILT_ZERO;
                    state <= 1'b0;
                end else if (sync2[g] == state) begin
                    cnt <= FILT_ZERO;
                end else if (cnt >= {1'b0, fault_filter_value}) begin
                    state <= sync2[g];
                    cnt <= FILT_ZERO;
                end else begin
                    cnt <= cnt + 5'h01;
                end
            end
            assign cond_in[g] = bypass ? sync2[g] : state;
        end
    endgenerate
    assign fault_input_status = cond_in;

    wire [NUM_FAULT-1:0] rise = cond_in & ~cond_q & fault_input_enable;
    wire fault_or = |(cond_in & fault_input_enable);
    wire fault_edge = fault_ctl_en && fault_or && !fault_or_q;
    // New PWM cycle at counter wrap
    wire new_cycle = (prev_counter == i_counter_modulo)
                     && (i_counter_value == i_counter_initial_value);
    wire release_ok = (fault_mode_select == FM_AUTO) ? !fault_or
                      : !summary_fault_flag;

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            sync1 <= 4'h0;
            sync2 <= 4'h0;
            cond_q <= 4'h0;
            fault_or_q <= 1'b0;
            prev_counter <= 16'h0000;
        end else begin
            sync1 <= i_fault_pin;
            sync2 <= sync1;
            cond_q <= cond_in;
            fault_or_q <= fault_or;
            prev_counter <= i_counter_value;
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            per_input_fault_flag <= 4'h0;
            flag_seen_one <= 1'b0;
        end else begin
            // Set wins over clear
            per_input_fault_flag <= (flag_clear ? 4'h0 : per_input_fault_flag)
                                    | (fault_ctl_en ? rise : 4'h0);
            if (bus.rd && bus.addr == ADDR_FLTSTAT) begin
                flag_seen_one <= summary_fault_flag;
            end else if (wr_fstat) begin
                flag_seen_one <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            fault_active <= 1'b0;
        end else if (fault_edge) begin
            fault_active <= 1'b1;
        end else if (fault_active && new_cycle && release_ok) begin
            fault_active <= 1'b0;
        end else if (!fault_ctl_en) begin
            fault_active <= 1'b0;
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            mode_reg <= RST_BYTE;
            fault_ctrl <= RST_BYTE;
            fault_filter_value <= 4'h0;
            channel_polarity <= 6'h00;
            channel_initial_output <= 6'h00;
            trig_ctrl <= 7'h00;
            pair_fault_enable <= 3'h0;
        end else if (bus.wr) begin
            case (bus.addr)
                ADDR_MODE: mode_reg <= {bus.wdata[7:2], 1'b0, bus.wdata[0]};
                ADDR_FLTCTRL: fault_ctrl <= bus.wdata;
                ADDR_FLTSTAT: fault_filter_value <= bus.wdata[3:0];
                ADDR_POL: channel_polarity <= bus.wdata[5:0];
                ADDR_OUTINIT: channel_initial_output <= bus.wdata[5:0];
                ADDR_TRIG: trig_ctrl <= bus.wdata[6:0];
                ADDR_PAIREN: pair_fault_enable <= bus.wdata[2:0];
                default: ;
            endcase
        end
    end

    // Initialisation holds the stored values until the next PWM cycle
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            init_hold <= 1'b0;
            init_val <= 6'h00;
        end else if (init_strobe && combine) begin
            init_hold <= 1'b1;
            init_val <= channel_initial_output;
        end else if (new_cycle) begin
            init_hold <= 1'b0;
        end
    end

    // Output path
    logic [NUM_CH-1:0] next_out;
    always_comb begin
        next_out = i_channel_pwm;
        if (combine) begin
            next_out = i_channel_pwm ^ channel_polarity;
            if (init_hold) begin
                next_out = init_val;
            end
            for (int p = 0; p < NUM_PAIR; p++) begin
                if (fault_active && pair_fault_enable[p]) begin
                    next_out[2*p +: 2] = channel_polarity[2*p +: 2];
                end
            end
        end
    end

    // Triggers
    logic [NUM_CH-1:0] next_match;
    always_comb begin
        for (int c = 0; c < NUM_CH; c++) begin
            next_match[c] = extended_feature_enable && combine && match_trigger_select[c]
                            && (i_counter_value == i_channel_value[c*16 +: 16]);
        end
    end
    wire cnt_write = wr_cnth || wr_cntl;
    wire next_reload = reload_trigger_enable && combine
                       && (new_cycle || cnt_write || i_counter_sync
                           || (i_clock_start && i_counter_value == i_counter_initial_value));

    // Capture test
    wire both_written = (wr_cnth || hi_written) && (wr_cntl || lo_written)
                        && capture_test_enable;
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            hi_written <= 1'b0;
            lo_written <= 1'b0;
            cap_hi <= RST_BYTE;
            cap_lo <= RST_BYTE;
        end else if (both_written || !capture_test_enable) begin
            hi_written <= 1'b0;
            lo_written <= 1'b0;
            if (wr_cnth) cap_hi <= bus.wdata;
            if (wr_cntl) cap_lo <= bus.wdata;
        end else begin
            if (wr_cnth) begin
                hi_written <= 1'b1;
                cap_hi <= bus.wdata;
            end
            if (wr_cntl) begin
                lo_written <= 1'b1;
                cap_lo <= bus.wdata;
            end
        end
    end
    wire [15:0] cap_word = {wr_cnth ? bus.wdata : cap_hi, wr_cntl ? bus.wdata : cap_lo};

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_channel_out <= 6'h00;
            o_match_trigger <= 6'h00;
            o_reload_trigger <= 1'b0;
            o_fault_irq <= 1'b0;
            o_counter_load <= 1'b0;
            o_counter_load_value <= 16'h0000;
            o_capture_load <= 1'b0;
            o_capture_value <= 16'h0000;
            o_channel_event_flag_set <= 6'h00;
        end else begin
            o_channel_out <= next_out;
            o_match_trigger <= next_match;
            o_reload_trigger <= next_reload;
            o_fault_irq <= summary_fault_flag && fault_interrupt_enable;
            o_counter_load <= cnt_write && capture_test_enable;
            o_counter_load_value <= cap_word;
            o_capture_load <= both_written;
            o_capture_value <= cap_word;
            o_channel_event_flag_set <= {NUM_CH{both_written}};
        end
    end
    assign o_counter_freeze = capture_test_enable;

    always_comb begin
        case (bus.addr)
            ADDR_MODE: rdata = mode_reg;
            ADDR_FLTCTRL: rdata = fault_ctrl;
            ADDR_FLTSTAT: rdata = {summary_fault_flag, 3'h0, fault_filter_value};
            ADDR_POL: rdata = {2'h0, channel_polarity};
            ADDR_OUTINIT: rdata = {2'h0, channel_initial_output};
            ADDR_TRIG: rdata = {1'b0, trig_ctrl};
            ADDR_PAIREN: rdata = {fault_input_status, 1'b0, pair_fault_enable};
            ADDR_CNTH: rdata = i_counter_value[15:8];
            ADDR_CNTL: rdata = i_counter_value[7:0];
            ADDR_CVH: rdata = i_channel_value[15:8];
            ADDR_CVL: rdata = {per_input_fault_flag, 4'h0} | i_channel_value[7:0];
            default: rdata = 8'h00;
        endcase
    end
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_rdata <= 8'h00;
        end else begin
            o_rdata <= bus.rd ? rdata : 8'h00;
        end
    end
endmodule

// *** rtl/pft_pkg.sv ***
package pft_pkg;
    localparam int NUM_FAULT = 4;
    localparam int NUM_CH = 6;
    localparam int NUM_PAIR = 3;
    localparam int FILT_W = 5;
    // Register indices on the plain register port
    localparam logic [3:0] ADDR_MODE = 4'h0;
    localparam logic [3:0] ADDR_FLTCTRL = 4'h1;
    localparam logic [3:0] ADDR_FLTSTAT = 4'h2;
    localparam logic [3:0] ADDR_POL = 4'h3;
    localparam logic [3:0] ADDR_OUTINIT = 4'h4;
    localparam logic [3:0] ADDR_TRIG = 4'h5;
    localparam logic [3:0] ADDR_CNTH = 4'h6;
    localparam logic [3:0] ADDR_CNTL = 4'h7;
    localparam logic [3:0] ADDR_PAIREN = 4'h8;
    localparam logic [3:0] ADDR_CVH = 4'h9;
    localparam logic [3:0] ADDR_CVL = 4'hA;
    // MODE fields
    localparam int MODE_EXT_BIT = 0;
    localparam int MODE_INIT_BIT = 1;
    localparam int MODE_FM_LSB = 2;
    localparam int MODE_FIE_BIT = 4;
    localparam int MODE_CAPT_BIT = 5;
    localparam int MODE_COMB_BIT = 6;
    // FLTCTRL: [3:0] input enables, [7:4] filter enables; TRIG: [5:0] match, [6] reload
    localparam int TRIG_RELOAD_BIT = 6;
    localparam logic [1:0] FM_OFF = 2'h0;
    localparam logic [1:0] FM_AUTO = 2'h3;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [FILT_W-1:0] FILT_ZERO = 5'h00;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } pft_bus_t;

    typedef struct packed {
        logic cnt_reload;
        logic cnt_sync;
        logic clk_start;
        logic [15:0] cnt_ext;
        logic [NUM_CH*16-1:0] ch_val;
    } pft_cnt_t;
endpackage

// *** verif/pft_control_checker.sv ***
`timescale 1ns/10ps
module pft_control_checker
    import pft_pkg::*;
(
    // Clock, reset, register port
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] o_rdata,
    // Counter side
    input wire logic [15:0] i_counter_value,
    input wire logic [NUM_CH*16-1:0] i_channel_value,
    input wire logic i_counter_sync,
    // Outputs
    input wire logic [NUM_CH-1:0] o_match_trigger,
    input wire logic o_reload_trigger,
    input wire logic o_fault_irq,
    input wire logic o_counter_freeze,
    input wire logic o_counter_load,
    input wire logic o_capture_load,
    input wire logic [15:0] o_capture_value,
    input wire logic [NUM_CH-1:0] o_channel_event_flag_set
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    logic [7:0] mode_q;
    logic [7:0] trig_q;
    wire wr_mode = i_wr && i_addr == ADDR_MODE;
    wire wr_trig = i_wr && i_addr == ADDR_TRIG;
    // Shadow of the mode and trigger registers
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            mode_q <= RST_BYTE;
            trig_q <= RST_BYTE;
        end else begin
            if (wr_mode)
                mode_q <= i_wdata;
            if (wr_trig)
                trig_q <= i_wdata;
        end
    end
    sequence s_hi;
        o_counter_freeze && i_wr && i_addr == ADDR_CNTH;
    endsequence
    sequence s_lo;
        o_counter_freeze && i_wr && i_addr == ADDR_CNTL;
    endsequence
    property p_rd_idle;
        !i_rd |=> o_rdata == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not zero");
    property p_freeze;
        wr_mode |=> o_counter_freeze == $past(i_wdata[MODE_CAPT_BIT]);
    endproperty
    a_freeze: assert property (p_freeze) else $error("freeze wrong");
    property p_cnt_load;
        s_hi |=> o_counter_load;
    endproperty
    a_cnt_load: assert property (p_cnt_load) else $error("no counter load");
    property p_cap_pair;
        s_hi ##1 s_lo |=> o_capture_load && o_channel_event_flag_set == 6'h3F
            && o_capture_value == {$past(i_wdata, 2), $past(i_wdata)};
    endproperty
    a_cap_pair: assert property (p_cap_pair) else $error("capture wrong");
    property p_irq_ie;
        o_fault_irq |-> mode_q[MODE_FIE_BIT] || $past(mode_q[MODE_FIE_BIT]);
    endproperty
    a_irq_ie: assert property (p_irq_ie) else $error("irq without enable");
    property p_irq_off;
        wr_mode && !i_wdata[MODE_FIE_BIT] |=> ##1 !o_fault_irq;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("irq stays set");
    property p_rel_trig;
        mode_q[MODE_COMB_BIT] && trig_q[TRIG_RELOAD_BIT] && i_counter_sync |=> o_reload_trigger;
    endproperty
    a_rel_trig: assert property (p_rel_trig) else $error("no reload trigger");
    property p_no_comb;
        !mode_q[MODE_COMB_BIT] && !$past(mode_q[MODE_COMB_BIT])
            |-> o_match_trigger == 6'h00 && !o_reload_trigger;
    endproperty
    a_no_comb: assert property (p_no_comb) else $error("trigger outside combine");
    property p_match;
        mode_q[MODE_EXT_BIT] && mode_q[MODE_COMB_BIT] && trig_q[0]
            && i_counter_value == i_channel_value[15:0] |=> o_match_trigger[0];
    endproperty
    a_match: assert property (p_match) else $error("no match trigger");
endmodule

bind pft_control pft_control_checker u_checker (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_counter_value(i_counter_value),
    .i_channel_value(i_channel_value), .i_counter_sync(i_counter_sync),
    .o_match_trigger(o_match_trigger), .o_reload_trigger(o_reload_trigger),
    .o_fault_irq(o_fault_irq), .o_counter_freeze(o_counter_freeze),
    .o_counter_load(o_counter_load), .o_capture_load(o_capture_load),
    .o_capture_value(o_capture_value), .o_channel_event_flag_set(o_channel_event_flag_set)
);

// *** verif/pft_stage_model.sv ***
`timescale 1ns/10ps
module pft_stage_model
    import pft_pkg::*;
#(
    parameter logic [15:0] INIT_VAL = 16'h0000,
    parameter logic [15:0] MOD_VAL = 16'h0007
) (
    // Clock and control
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_run,
    input wire logic [NUM_FAULT-1:0] i_fault_req,
    // Pins and counter state
    output logic [NUM_FAULT-1:0] o_fault_pin,
    output logic [15:0] o_counter_value,
    output logic [15:0] o_counter_initial_value,
    output logic [15:0] o_counter_modulo,
    output logic o_clock_start
);
    logic run_q;
    wire at_mod = o_counter_value == MOD_VAL;
    assign o_fault_pin = i_fault_req;
    assign o_counter_initial_value = INIT_VAL;
    assign o_counter_modulo = MOD_VAL;
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_counter_value <= INIT_VAL;
            run_q <= 1'b0;
            o_clock_start <= 1'b0;
        end else begin
            run_q <= i_run;
            // Start pulse only from a stopped counter at its initial value
            o_clock_start <= i_run && !run_q && o_counter_value == INIT_VAL;
            if (i_run)
                o_counter_value <= at_mod ? INIT_VAL : o_counter_value + 16'h0001;
        end
    end
endmodule

// *** verif/pwm_fault_trigger_control_tb_top.sv ***
`timescale 1ns/10ps
module pwm_fault_trigger_control_tb_top;
    import pft_pkg::*;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic sync = 1'b0;
    logic run = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [3:0] fault_req = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdat;
    logic [5:0] pwm = 6'h0F;
    logic [95:0] chv = {80'h0, 16'h0003};
    wire [15:0] cnt, cnt_init, cnt_mod, cap_v, ld_v;
    wire [3:0] pins;
    wire [7:0] rdata;
    wire [5:0] ch_out;
    wire clk_start, irq, rtrig, freeze, cap_ld;
    int failures = 0;
    int total_checks = 0;
    int cycles = 0;
    pft_control dut (.i_mclk(mclk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
        .i_rd(rd), .o_rdata(rdata), .i_fault_pin(pins), .i_counter_value(cnt),
        .i_counter_initial_value(cnt_init), .i_counter_modulo(cnt_mod), .i_channel_value(chv),
        .i_channel_pwm(pwm), .i_counter_sync(sync), .i_clock_start(clk_start),
        .o_channel_out(ch_out), .o_match_trigger(), .o_reload_trigger(rtrig), .o_fault_irq(irq),
        .o_counter_freeze(freeze), .o_counter_load(), .o_counter_load_value(ld_v),
        .o_capture_load(cap_ld), .o_capture_value(cap_v), .o_channel_event_flag_set());
    pft_stage_model stage (.i_mclk(mclk), .i_rst(rst), .i_run(run), .i_fault_req(fault_req),
        .o_fault_pin(pins), .o_counter_value(cnt), .o_counter_initial_value(cnt_init),
        .o_counter_modulo(cnt_mod), .o_clock_start(clk_start));
    initial begin
        forever #50 mclk = ~mclk;
    end
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        rd <= 1'b0;
        wr <= 1'b1;
        @(posedge mclk);
    endtask
    task automatic rd_reg(input logic [3:0] a);
        addr <= a;
        wr <= 1'b0;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        rdat = rdata;
    endtask
    task automatic cyc(input int n);
        wr <= 1'b0;
        rd <= 1'b0;
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic done(input int n);
        $display("test %0d finished", n);
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            end_of_test();
        end
    end
    initial begin
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        wr_reg(ADDR_FLTSTAT, 8'h05);
        wr_reg(4'hF, 8'hFF);
        rd_reg(ADDR_FLTSTAT);
        chk(rdat, 8'h05);
        rd_reg(4'hF);
        chk(rdat, 8'h00);
        done(1);
        wr_reg(ADDR_POL, 8'h2A);
        cyc(3);
        chk(ch_out, 6'h0F);
        wr_reg(ADDR_MODE, 8'h40);
        cyc(3);
        chk(ch_out, 6'h25);
        done(2);
        // Manual clearing, filter bypassed on input 0
        wr_reg(ADDR_MODE, 8'h55);
        wr_reg(ADDR_FLTCTRL, 8'h01);
        wr_reg(ADDR_PAIREN, 8'h01);
        cyc(1);
        fault_req <= 4'h1;
        cyc(2);
        chk(irq, 1'b0);
        cyc(2);
        chk(irq, 1'b1);
        cyc(2);
        chk(ch_out, 6'h26);
        rd_reg(ADDR_PAIREN);
        chk(rdat & 8'hF0, 8'h10);
        rd_reg(ADDR_FLTSTAT);
        chk(rdat, 8'h85);
        wr_reg(ADDR_FLTSTAT, 8'h05);
        cyc(2);
        chk(irq, 1'b0);
        cyc(20);
        chk(ch_out, 6'h25);
        fault_req <= 4'h0;
        done(3);
        // Automatic clearing, filter value 2 on input 1
        wr_reg(ADDR_MODE, 8'h5D);
        wr_reg(ADDR_FLTCTRL, 8'h22);
        wr_reg(ADDR_FLTSTAT, 8'h02);
        cyc(20);
        fault_req <= 4'h2;
        cyc(1);
        fault_req <= 4'h0;
        cyc(12);
        chk(irq, 1'b0);
        fault_req <= 4'h2;
        cyc(5);
        chk(irq, 1'b0);
        cyc(3);
        chk({irq, ch_out}, 7'h66);
        fault_req <= 4'h0;
        cyc(30);
        chk({irq, ch_out}, 7'h65);
        rd_reg(ADDR_FLTSTAT);
        chk(rdat, 8'h82);
        wr_reg(ADDR_FLTSTAT, 8'h02);
        done(4);
        run <= 1'b0;
        wr_reg(ADDR_OUTINIT, 8'h15);
        wr_reg(ADDR_MODE, 8'h42);
        cyc(3);
        chk(ch_out, 6'h15);
        done(5);
        wr_reg(ADDR_TRIG, 8'h41);
        wr_reg(ADDR_MODE, 8'h41);
        cyc(1);
        sync <= 1'b1;
        cyc(1);
        chk(rtrig, 1'b1);
        sync <= 1'b0;
        run <= 1'b1;
        cyc(40);
        done(6);
        // Capture test, both byte orders
        wr_reg(ADDR_MODE, 8'h21);
        wr_reg(ADDR_CNTH, 8'h12);
        wr_reg(ADDR_CNTL, 8'h34);
        #1;
        chk({freeze, cap_ld, cap_v}, {2'b11, 16'h1234});
        chk(ld_v, 16'h1234);
        wr_reg(ADDR_CNTL, 8'h78);
        wr_reg(ADDR_CNTH, 8'h56);
        #1;
        chk({cap_ld, cap_v}, {1'b1, 16'h5678});
        cyc(2);
        done(7);
        end_of_test();
    end
endmodule
